/* logic/sps_cfg.svh */
// Constants for the serial port select and master transmit block.
`ifndef SPS_CFG_SVH
`define SPS_CFG_SVH
// ==========================================================
// Clock and serial timing
`define SPS_CLK_MHZ 250
`define SPS_SCK_HALF_NS 16
`define SPS_HALF_CYC ((`SPS_SCK_HALF_NS * `SPS_CLK_MHZ + 999) / 1000)
// ==========================================================
// Select mode encodings and field positions
`define SPS_MODE_3WIRE 2'h0
`define SPS_MODE_4W_IN 2'h1
`define SPS_MODE_HI_BIT 1
`define SPS_MODE_LVL_BIT 0
`define SPS_CTL_DONE_BIT 7
`define SPS_CTL_MASTER_BIT 6
// ==========================================================
// Synchroniser lanes, reset values and buffer sizes
`define SPS_IX_SCK 0
`define SPS_IX_MOSI 1
`define SPS_IX_MISO 2
`define SPS_IX_SS 3
// Reset values match the idle pin levels (clock low, select high), so no
// false clock or select edge is seen when reset is released.
`define SPS_SYNC_RST 4'h8
`define SPS_BYTE_RST 8'h00
`define SPS_FIFO_DEPTH 16
`define SPS_WORD_W 8
`endif

/* logic/sps_pkg.sv */
// Types shared by the serial port select and master transmit block.
package sps_pkg;
  // ==========================================================
  // Master sequencer states
  typedef enum logic [1:0] {
    SPS_IDLE = 2'b00,
    SPS_LOW = 2'b01,
    SPS_HIGH = 2'b10
  } sps_state_t;

  // ==========================================================
  // Pin drive group
  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
    logic ss_n;
    logic ss_n_oe;
  } sps_pin_out_t;

  // ==========================================================
  // Registered state of the serial core, apart from the transmit buffer
  typedef struct packed {
    logic [3:0] meta;
    logic [3:0] sync;
    logic [3:0] prev;
    sps_state_t st;
    logic [7:0] shreg;
    logic [2:0] bitn;
    logic [7:0] cnt;
    logic samp;
    logic busy;
    logic fault;
    logic done;
    logic irq;
    logic routed;
    logic [7:0] rx;
    sps_pin_out_t pins;
  } sps_core_t;
endpackage

/* logic/sps_fifo.sv */
// Transmit buffer FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module sps_fifo #(
  parameter int W = 8,
  parameter int D = 16,
  parameter int AW = $clog2(D)
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } sps_fifo_st_t;

  sps_fifo_st_t q, d;
  logic full, empty;

  assign empty = (q.wp == q.rp);
  assign full = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = q.mem[q.rp[AW-1:0]];

  always_comb begin
    d = q;
    if (in_valid && !full) begin
      d.mem[q.wp[AW-1:0]] = in_data;
      d.wp = q.wp + 1'b1;
    end
    if (out_ready && !empty) begin
      d.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  fifo_count_a: assert property (
    (in_valid && !full && !(out_ready && !empty)) |=> !empty)
    else $error("fifo lost a written word");
endmodule // sps_fifo

/* logic/sps_core.sv */
// Serial port with select modes, master transmit and slave receive.
`timescale 1ns/100ps
`include "sps_cfg.svh"
module sps_core import sps_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control bits
  input wire logic port_enable,
  input wire logic master_enable_bit,
  input wire logic [1:0] select_mode_field,
  input wire logic int_enable,
  input wire logic flag_clear,
  // Data port
  input wire logic data_valid,
  input wire logic [7:0] serial_port_data_reg,
  output logic data_ready,
  // Status
  output logic transfer_complete_flag,
  output logic master_fault,
  output logic irq_req,
  output logic select_routed,
  output logic [7:0] rx_data,
  // Serial pins
  input wire logic sck_in,
  input wire logic mosi_in,
  input wire logic miso_in,
  input wire logic slave_select_n_in,
  output sps_pin_out_t pins
);
  localparam logic [7:0] HALF_LAST = 8'(`SPS_HALF_CYC - 1);

  // ==========================================================
  // Decode helpers
  // Slave addressing by mode.
  function automatic logic slave_sel(input logic [1:0] m, input logic ssn);
    slave_sel = (m == `SPS_MODE_3WIRE) || (m == `SPS_MODE_4W_IN && !ssn);
  endfunction

  sps_core_t q, n;
  logic tx_valid, tx_ready, pop, set_done, master, selected;
  logic rise, fall, ss_fall;
  logic [7:0] tx_byte;

  // ==========================================================
  // Transmit buffer
  // Buffered data writes.
  sps_fifo #(.W(`SPS_WORD_W), .D(`SPS_FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(data_valid),
    .in_data(serial_port_data_reg),
    .in_ready(data_ready),
    .out_valid(tx_valid),
    .out_data(tx_byte),
    .out_ready(tx_ready)
  );
  assign tx_ready = pop;

  // ==========================================================
  // Next state
  always_comb begin
    n = q;
    pop = 1'b0;
    set_done = 1'b0;
    n.meta = {slave_select_n_in, miso_in, mosi_in, sck_in};
    n.sync = q.meta;
    n.prev = q.sync;
    master = port_enable && master_enable_bit && !q.fault;
    selected = port_enable && !master_enable_bit
      && slave_sel(select_mode_field, q.sync[`SPS_IX_SS]);
    rise = !q.prev[`SPS_IX_SCK] && q.sync[`SPS_IX_SCK];
    fall = q.prev[`SPS_IX_SCK] && !q.sync[`SPS_IX_SCK];
    ss_fall = q.prev[`SPS_IX_SS] && !q.sync[`SPS_IX_SS];
    if (!master_enable_bit) begin
      n.fault = 1'b0;
    end else if (select_mode_field == `SPS_MODE_4W_IN && ss_fall) begin
      n.fault = 1'b1;
    end
    case (q.st)
      SPS_IDLE: begin
        n.cnt = 8'h00;
        if (master && tx_valid) begin
          pop = 1'b1;
          n.shreg = tx_byte;
          n.bitn = 3'h0;
          n.st = SPS_LOW;
        end else if (!master_enable_bit) begin
          if (!selected) begin
            n.bitn = 3'h0;
            n.busy = 1'b0;
          end else begin
            if (q.bitn == 3'h0 && !q.busy && tx_valid) begin
              pop = 1'b1;
              n.shreg = tx_byte;
              n.busy = 1'b1;
            end
            if (rise) begin
              n.samp = q.sync[`SPS_IX_MOSI];
            end
            if (fall) begin
              n.shreg = {q.shreg[6:0], q.samp};
              n.bitn = q.bitn + 3'h1;
              if (q.bitn == 3'h7) begin
                set_done = 1'b1;
                n.busy = 1'b0;
                n.rx = {q.shreg[6:0], q.samp};
              end
            end
          end
        end
      end
      SPS_LOW: begin
        if (!master) begin
          n.st = SPS_IDLE;
        end else if (q.cnt == HALF_LAST) begin
          n.cnt = 8'h00;
          n.samp = q.sync[`SPS_IX_MISO];
          n.st = SPS_HIGH;
        end else begin
          n.cnt = q.cnt + 8'h01;
        end
      end
      SPS_HIGH: begin
        if (!master) begin
          n.st = SPS_IDLE;
        end else if (q.cnt == HALF_LAST) begin
          n.cnt = 8'h00;
          n.shreg = {q.shreg[6:0], q.samp};
          if (q.bitn == 3'h7) begin
            set_done = 1'b1;
            n.rx = {q.shreg[6:0], q.samp};
            n.st = SPS_IDLE;
          end else begin
            n.bitn = q.bitn + 3'h1;
            n.st = SPS_LOW;
          end
        end else begin
          n.cnt = q.cnt + 8'h01;
        end
      end
      default: begin
        n.st = SPS_IDLE;
      end
    endcase
    // Set wins over a clear in the same cycle.
    n.done = set_done || (q.done && !flag_clear);
    n.irq = int_enable && n.done;
    n.routed = (select_mode_field != `SPS_MODE_3WIRE);
    n.pins.sck = master && (q.st == SPS_HIGH);
    n.pins.sck_oe = master;
    n.pins.mosi = q.shreg[7];
    n.pins.mosi_oe = master;
    n.pins.miso = q.shreg[7];
    n.pins.miso_oe = selected;
    // Output select; level from the low bit.
    n.pins.ss_n = select_mode_field[`SPS_MODE_LVL_BIT];
    n.pins.ss_n_oe = port_enable && select_mode_field[`SPS_MODE_HI_BIT];
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.meta <= `SPS_SYNC_RST;
      q.sync <= `SPS_SYNC_RST;
      q.prev <= `SPS_SYNC_RST;
      q.shreg <= `SPS_BYTE_RST;
      q.st <= SPS_IDLE;
    end else begin
      q <= n;
    end
  end

  assign transfer_complete_flag = q.done;
  assign master_fault = q.fault;
  assign irq_req = q.irq;
  assign select_routed = q.routed;
  assign rx_data = q.rx;
  assign pins = q.pins;

  // ==========================================================
  // Checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  ss_level_a: assert property (
    (port_enable && select_mode_field[1]) |=>
      (pins.ss_n_oe && pins.ss_n == $past(select_mode_field[0])))
    else $error("select output level wrong");
  ss_input_a: assert property (
    !select_mode_field[1] |=> !pins.ss_n_oe)
    else $error("select driven in input mode");
  route_sel_a: assert property (
    ##1 select_routed == ($past(select_mode_field) != 2'h0))
    else $error("select routing wrong");
  mm_fault_a: assert property (
    (master_enable_bit && select_mode_field == 2'h1 && ss_fall) |=>
      q.fault ##1 !pins.sck_oe)
    else $error("master not disabled by select");
  fault_hold_a: assert property (
    (q.fault && master_enable_bit) |=> (q.fault && !pins.mosi_oe))
    else $error("faulted master resumed");
  miso_off_a: assert property (
    (!port_enable || master_enable_bit) |=> !pins.miso_oe)
    else $error("slave output driven when off");
  sck_ignore_a: assert property (
    (select_mode_field == 2'h1 && !master_enable_bit &&
     q.sync[`SPS_IX_SS] && q.st == SPS_IDLE) |=> q.bitn == 3'h0)
    else $error("unselected slave counted clock");
  done_set_a: assert property (
    set_done |=> q.done)
    else $error("complete flag not set");
  irq_flag_a: assert property (
    ($rose(q.done) && $past(int_enable)) |-> irq_req)
    else $error("interrupt missing");
  mosi_msb_a: assert property (
    (q.st == SPS_LOW && master) |=> pins.mosi == $past(q.shreg[7]))
    else $error("mosi not from msb");
  xfer_end_a: assert property (
    (pop && master) |-> ##[60:70] (q.done || !master))
    else $error("master transfer did not finish");

  m_done_c: cover property (q.st == SPS_HIGH ##[1:10] set_done);
  fault_c: cover property ($rose(q.fault));
  slv_byte_c: cover property (!master_enable_bit && set_done);
  ss_high_c: cover property (pins.ss_n_oe && pins.ss_n);
endmodule // sps_core

/* testbench/sps_far_end.sv */
// Far-end serial slave that answers a fixed byte and records what it hears.
`timescale 1ns/100ps
module sps_far_end (
  // Serial pins
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // Observation
  input wire logic [7:0] reply,
  output logic [7:0] heard,
  output int bytes
);
  logic [2:0] rise_n = 3'h0;
  logic [2:0] fall_n = 3'h0;
  initial heard = 8'h00;
  initial bytes = 0;
  // ==========================================================
  // Capture and reply
  // The bit counters never resync, so an aborted byte skews later counts.
  // MSB first, eight rises per byte.
  always @(posedge sck) begin
    heard <= {heard[6:0], mosi};
    rise_n <= rise_n + 3'h1;
    if (rise_n == 3'h7) bytes <= bytes + 1;
  end
  // Reply MSB first, moving only after a falling edge.
  always @(negedge sck) fall_n <= fall_n + 3'h1;
  assign miso = reply[3'h7 - fall_n];
endmodule // sps_far_end

/* testbench/test_sps_core.sv */
// Self-checking bench for the serial select and master transmit core.
`timescale 1ns/100ps
module test_sps_core import sps_pkg::*; ();
  // ==========================================================
  // Signals
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b0;
  logic men = 1'b0;
  logic [1:0] md = 2'h0;
  logic ien = 1'b0;
  logic clr = 1'b0;
  logic dv = 1'b0;
  logic [7:0] wd = 8'h00;
  logic ssck = 1'b0;
  logic smosi = 1'b0;
  logic ss_n_in = 1'b1;
  logic drdy, flag, fault, irq, routed, miso;
  logic [7:0] rxd, heard;
  int nb;
  int errors = 0;
  int compares = 0;
  sps_pin_out_t pins;
  always #2 ref_clk = ~ref_clk;
  sps_core sps_core_inst (.ref_clk(ref_clk), .rst(rst), .port_enable(en),
    .master_enable_bit(men), .select_mode_field(md), .int_enable(ien),
    .flag_clear(clr), .data_valid(dv), .serial_port_data_reg(wd),
    .data_ready(drdy), .transfer_complete_flag(flag), .master_fault(fault),
    .irq_req(irq), .select_routed(routed), .rx_data(rxd), .sck_in(ssck),
    .mosi_in(smosi), .miso_in(miso), .slave_select_n_in(ss_n_in),
    .pins(pins));
  sps_far_end sps_far_end_inst (.sck(pins.sck), .mosi(pins.mosi),
    .miso(miso), .reply(8'h96), .heard(heard), .bytes(nb));
  // ==========================================================
  // Helpers
  task automatic chk(string w, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wflag();
    for (int i = 0; i < 300 && flag !== 1'b1; i++) cyc(1);
    cyc(1);
  endtask
  task automatic unflag();
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(1);
  endtask
  // Link half periods are whole core cycles, so pins change on falling edges.
  task automatic sbyte(logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      smosi = b[i];
      #24 ssck = 1'b1;
      #24 ssck = 1'b0;
    end
    cyc(8);
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic modes();
    // Select output modes are used only as master.
    en = 1'b1;
    men = 1'b1;
    for (int m = 0; m < 4; m++) begin
      md = 2'(m);
      cyc(3);
      chk("routed", 8'(m != 0), routed); // pin routing
      chk("ss_oe", 8'(m / 2), pins.ss_n_oe); // select output
      if (m >= 2) chk("ss_lvl", 8'(m % 2), pins.ss_n); // select level
    end
  endtask
  task automatic master();
    int base;
    base = nb;
    md = 2'h2;
    ien = 1'b1;
    dv = 1'b1;
    wd = 8'ha5;
    cyc(1);
    wd = 8'h3c;
    cyc(1);
    dv = 1'b0;
    chk("sck_oe", 8'h01, pins.sck_oe); // master drives
    wflag();
    chk("flag", 8'h01, flag); // flag set
    chk("heard", 8'ha5, heard); // data out
    chk("rx", 8'h96, rxd); // data in
    chk("irq", 8'h01, irq); // request raised
    chk("bytes", 8'(base + 1), 8'(nb)); // one byte
    ien = 1'b0;
    unflag();
    wflag();
    chk("heard2", 8'h3c, heard); // next byte
    chk("irq_off", 8'h00, irq); // request gated
    unflag();
  endtask
  task automatic fill_drain();
    int n;
    int base;
    n = 0;
    base = nb;
    dv = 1'b1;
    wd = 8'h69;
    repeat (20) begin
      if (drdy === 1'b1) n++;
      cyc(1);
    end
    dv = 1'b0;
    chk("depth", 8'h01, 8'(n == 16 || n == 17)); // buffer depth
    for (int i = 0; i < 2000 && nb != base + n; i++) cyc(1);
    chk("drained", 8'(base + n), 8'(nb)); // all sent
    chk("ready", 8'h01, drdy); // buffer not full
    // Let the last byte finish before its flag is cleared.
    cyc(8);
    unflag();
  endtask
  task automatic fault_case();
    md = 2'h1;
    cyc(3);
    wd = 8'hf0;
    dv = 1'b1;
    cyc(1);
    dv = 1'b0;
    cyc(12);
    ss_n_in = 1'b0;
    cyc(8);
    chk("fault", 8'h01, fault); // master disabled
    cyc(100);
    chk("sck_off", 8'h00, pins.sck_oe); // clock quiet
    chk("mosi_off", 8'h00, pins.mosi_oe); // data quiet
    chk("abort", 8'h00, flag); // no completion
    men = 1'b0;
    cyc(3);
    chk("unfault", 8'h00, fault); // re-enable path
    ss_n_in = 1'b1;
  endtask
  task automatic slave();
    cyc(4);
    chk("miso_oe", 8'h00, pins.miso_oe); // unselected off
    sbyte(8'h5a);
    chk("ignored", 8'h00, flag); // clock ignored
    ss_n_in = 1'b0;
    cyc(4);
    chk("miso_on", 8'h01, pins.miso_oe); // selected drives
    sbyte(8'hc3);
    chk("rx4w", 8'hc3, rxd); // byte taken
    chk("miso_msb", 8'h01, 8'(pins.miso)); // msb drives
    unflag();
    md = 2'h0;
    ss_n_in = 1'b1;
    sbyte(8'h5a);
    chk("rx3w", 8'h5a, rxd); // always selected
    chk("miso_msb3", 8'h00, 8'(pins.miso)); // three wire drives
    unflag();
    en = 1'b0;
    cyc(3);
    chk("miso_dis", 8'h00, pins.miso_oe); // disabled off
  endtask
  // ==========================================================
  // Sequence and watchdog
  initial begin
    cyc(6);
    chk("rst_ready", 8'h01, drdy); // buffer not full
    rst = 1'b0;
    cyc(1);
    modes();
    master();
    fill_drain();
    fault_case();
    slave();
    tally_and_finish();
  end
  // The whole run needs about 1800 cycles; this leaves ample margin.
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
endmodule // test_sps_core
